// ---- rtl/psl_regs.sv ----
// command register bank with a link-clock command port
`timescale 1ns/100ps
module psl_regs (
	// core clock and reset
	input  wire  logic                             core_clk,
	input  wire  logic                             rst_b,
	input  wire  logic                             core_ce,
	// link side command port
	input  wire  logic                             link_clk,
	input  wire  logic                             link_cmd_valid,
	input  wire  logic                             link_cmd_write,
	input  wire  logic [7:0]                       link_cmd_code,
	input  wire  logic                             link_cmd_page,
	input  wire  logic [15:0]                      link_cmd_wdata,
	output wire  logic                             link_busy,
	output wire  logic                             link_rsp_valid,
	output wire  logic [15:0]                      link_rsp_data,
	output wire  logic                             link_rsp_err,
	// per output and device-wide conditions, core domain
	input  wire  logic [psl_pkg::NUM_OUT-1:0]      out_enabled,
	input  wire  logic [psl_pkg::NUM_OUT-1:0]      out_power_good,
	input  wire  logic [psl_pkg::NUM_OUT-1:0]      output_overvoltage_flag,
	input  wire  logic [psl_pkg::NUM_OUT-1:0]      output_overcurrent_flag,
	input  wire  logic [psl_pkg::NUM_OUT-1:0]      temp_flag,
	input  wire  logic                             input_undervoltage_flag,
	input  wire  logic                             comm_memory_logic_flag,
	input  wire  logic                             other_change_flag,
	// settings in force, commit pulse and fault summary byte
	output wire  logic [15:0]                      act_input_overcurrent_limit,
	output wire  logic [psl_pkg::NUM_OUT-1:0][15:0] act_turn_on_delay,
	output wire  logic [psl_pkg::NUM_OUT-1:0][15:0] act_turn_on_ramp_time,
	output wire  logic [psl_pkg::NUM_OUT-1:0][15:0] act_turn_off_delay,
	output wire  logic [psl_pkg::NUM_OUT-1:0][15:0] act_turn_off_ramp_time,
	output wire  logic                             commit_pulse,
	output wire  logic [7:0]                       fault_summary_byte
);
	import psl_pkg::*;

	// ***********************
	// link domain state
	// ***********************
	typedef struct packed {
		logic        busy;
		logic        req_tgl;
		logic        write;
		logic [7:0]  code;
		logic        page;
		logic [15:0] wdata;
		logic        ack_s1;
		logic        ack_s2;
		logic        ack_s3;
		logic        rsp_valid;
		logic [15:0] rsp_data;
		logic        rsp_err;
	} psl_link_t;

	// ***********************
	// core domain state
	// ***********************
	typedef struct packed {
		logic                      req_s1;
		logic                      req_s2;
		logic                      req_s3;
		logic                      ack_tgl;
		logic [15:0]               rdata;
		logic                      rerr;
		logic [15:0]               oc_stage;
		logic [15:0]               oc_act;
		logic [NUM_OUT-1:0][15:0]  on_dly;
		logic [NUM_OUT-1:0][15:0]  on_ramp_stage;
		logic [NUM_OUT-1:0][15:0]  on_ramp_act;
		logic [NUM_OUT-1:0][15:0]  off_dly;
		logic [NUM_OUT-1:0][15:0]  off_ramp_stage;
		logic [NUM_OUT-1:0][15:0]  off_ramp_act;
		logic                      commit;
		logic [7:0]                sum;
		logic [2:0]                word_hi;
	} psl_core_t;

	psl_link_t link_reg;
	psl_link_t link_next;
	psl_core_t core_reg;
	psl_core_t core_next;
	logic [NUM_OUT-1:0] out_off;
	logic               req_seen;
	logic [2:0]         flt_now;
	logic [2:0]         misc_now;
	logic [15:0]        sel_on_dly;
	logic [15:0]        oth_on_dly;
	logic [15:0]        sel_on_ramp;
	logic [15:0]        sel_off_dly;
	logic [15:0]        sel_off_ramp;

	// ***********************
	// link side handshake
	// ***********************
	always_comb begin
		link_next = link_reg;
		link_next.ack_s1 = core_reg.ack_tgl;
		link_next.ack_s2 = link_reg.ack_s1;
		link_next.ack_s3 = link_reg.ack_s2;
		link_next.rsp_valid = 1'b0;
		if (link_reg.ack_s2 != link_reg.ack_s3) begin
			link_next.busy = 1'b0;
			link_next.rsp_valid = 1'b1;
			link_next.rsp_data = core_reg.rdata;
			link_next.rsp_err = core_reg.rerr;
		end else if (link_cmd_valid && !link_reg.busy) begin
			link_next.busy = 1'b1;
			link_next.req_tgl = ~link_reg.req_tgl;
			link_next.write = link_cmd_write;
			link_next.code = link_cmd_code;
			link_next.page = link_cmd_page;
			link_next.wdata = link_cmd_wdata;
		end
	end

	always_ff @(posedge link_clk or negedge rst_b) begin
		if (!rst_b) begin
			link_reg <= '0;
		end else begin
			link_reg <= link_next;
		end
	end

	// ***********************
	// per output power state
	// ***********************
	genvar gi;
	generate
		for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
			assign out_off[gi] = ~(out_enabled[gi] & out_power_good[gi]);
		end
	endgenerate

	assign req_seen = core_reg.req_s2 != core_reg.req_s3;

	// ***********************
	// core access and summary
	// ***********************
	always_comb begin
		core_next = core_reg;
		core_next.req_s1 = link_reg.req_tgl;
		core_next.req_s2 = core_reg.req_s1;
		core_next.req_s3 = core_reg.req_s2;
		core_next.commit = 1'b0;
		if (req_seen) begin
			core_next.ack_tgl = ~core_reg.ack_tgl;
			core_next.rdata = 16'h0000;
			core_next.rerr = 1'b0;
			case (link_reg.code)
				CMD_IN_OC_LIMIT: begin
					if (link_reg.write) begin
						core_next.oc_stage = link_reg.wdata;
					end
					core_next.rdata = core_reg.oc_stage;
				end
				CMD_ON_DELAY: begin
					if (link_reg.write) begin
						core_next.on_dly[link_reg.page] = link_reg.wdata;
					end
					core_next.rdata = core_reg.on_dly[link_reg.page];
				end
				CMD_ON_RAMP: begin
					if (link_reg.write) begin
						core_next.on_ramp_stage[link_reg.page] = link_reg.wdata;
					end
					core_next.rdata = core_reg.on_ramp_stage[link_reg.page];
				end
				CMD_OFF_DELAY: begin
					if (link_reg.write) begin
						core_next.off_dly[link_reg.page] = link_reg.wdata;
					end
					core_next.rdata = core_reg.off_dly[link_reg.page];
				end
				CMD_OFF_RAMP: begin
					if (link_reg.write) begin
						core_next.off_ramp_stage[link_reg.page] = link_reg.wdata;
					end
					core_next.rdata = core_reg.off_ramp_stage[link_reg.page];
				end
				CMD_SUM_BYTE: begin
					core_next.rerr = link_reg.write;
					core_next.rdata = {8'h00, core_reg.sum};
				end
				CMD_SUM_WORD: begin
					core_next.rerr = link_reg.write;
					core_next.rdata = {core_reg.word_hi, 5'h00, core_reg.sum};
				end
				CMD_COMMIT: begin
					if (link_reg.write) begin
						core_next.commit = 1'b1;
						core_next.oc_act = core_reg.oc_stage;
						core_next.on_ramp_act = core_reg.on_ramp_stage;
						core_next.off_ramp_act = core_reg.off_ramp_stage;
					end else begin
						core_next.rerr = 1'b1;
					end
				end
				default: begin
					core_next.rerr = 1'b1;
				end
			endcase
		end
		core_next.sum[SUM_UNUSED] = 1'b0;
		core_next.sum[SUM_OFF] = |out_off;
		core_next.sum[SUM_OV] = |output_overvoltage_flag;
		core_next.sum[SUM_OC] = |output_overcurrent_flag;
		core_next.sum[SUM_UV] = input_undervoltage_flag;
		core_next.sum[SUM_TEMP] = |temp_flag;
		core_next.sum[SUM_CML] = comm_memory_logic_flag;
		core_next.sum[SUM_OTHER] = other_change_flag;
		core_next.word_hi = {|output_overvoltage_flag, |output_overcurrent_flag, input_undervoltage_flag};
		if (!core_ce) begin
			core_next = core_reg;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			core_reg <= '0;
			core_reg.oc_stage <= RST_IN_OC_LIMIT;
			core_reg.oc_act <= RST_IN_OC_LIMIT;
			core_reg.on_dly <= {NUM_OUT{RST_ON_DELAY}};
			core_reg.on_ramp_stage <= {NUM_OUT{RST_ON_RAMP}};
			core_reg.on_ramp_act <= {NUM_OUT{RST_ON_RAMP}};
			core_reg.off_dly <= {NUM_OUT{RST_OFF_DELAY}};
			core_reg.off_ramp_stage <= {NUM_OUT{RST_OFF_RAMP}};
			core_reg.off_ramp_act <= {NUM_OUT{RST_OFF_RAMP}};
			core_reg.sum <= RST_SUM_BYTE;
		end else begin
			core_reg <= core_next;
		end
	end

	// ***********************
	// outputs
	// ***********************
	assign link_busy                   = link_reg.busy;
	assign link_rsp_valid              = link_reg.rsp_valid;
	assign link_rsp_data               = link_reg.rsp_data;
	assign link_rsp_err                = link_reg.rsp_err;
	assign act_input_overcurrent_limit = core_reg.oc_act;
	assign act_turn_on_delay           = core_reg.on_dly;
	assign act_turn_on_ramp_time       = core_reg.on_ramp_act;
	assign act_turn_off_delay          = core_reg.off_dly;
	assign act_turn_off_ramp_time      = core_reg.off_ramp_act;
	assign commit_pulse                = core_reg.commit;
	assign fault_summary_byte          = core_reg.sum;

	// ***********************
	// checks
	// ***********************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	assign flt_now      = {|output_overvoltage_flag, |output_overcurrent_flag, input_undervoltage_flag};
	assign misc_now     = {|temp_flag, comm_memory_logic_flag, other_change_flag};
	assign sel_on_dly   = core_reg.on_dly[link_reg.page];
	assign oth_on_dly   = core_reg.on_dly[~link_reg.page];
	assign sel_on_ramp  = core_reg.on_ramp_stage[link_reg.page];
	assign sel_off_dly  = core_reg.off_dly[link_reg.page];
	assign sel_off_ramp = core_reg.off_ramp_stage[link_reg.page];

	sequence s_access(logic [7:0] c, logic w);
		core_ce && req_seen && link_reg.code == c && link_reg.write == w;
	endsequence

	a_oc_hold_uncommitted: assert property (!(core_ce && core_next.commit) |=> $stable(core_reg.oc_act))
		else $error("overcurrent limit changed without commit");
	a_commit_copies_stage: assert property (s_access(CMD_COMMIT, 1'b1) |=> commit_pulse
		&& core_reg.oc_act == $past(core_reg.oc_stage) && core_reg.on_ramp_act == $past(core_reg.on_ramp_stage))
		else $error("commit did not copy staged settings");
	a_oc_read_global: assert property (s_access(CMD_IN_OC_LIMIT, 1'b0) |=>
		core_reg.rdata == $past(core_reg.oc_stage))
		else $error("overcurrent limit readback wrong");
	a_on_delay_paged: assert property (s_access(CMD_ON_DELAY, 1'b1) |=>
		core_reg.on_dly[$past(link_reg.page)] == $past(link_reg.wdata)
		&& core_reg.on_dly[~$past(link_reg.page)] == $past(oth_on_dly))
		else $error("turn on delay page write wrong");
	a_sum_bit7_zero: assert property (fault_summary_byte[SUM_UNUSED] == 1'b0)
		else $error("summary bit 7 set");
	a_sum_off_flag: assert property (core_ce && (|out_off) |=> fault_summary_byte[SUM_OFF])
		else $error("off flag missing");
	a_sum_fault_or: assert property (core_ce |=> fault_summary_byte[SUM_OV:SUM_UV] == $past(flt_now))
		else $error("fault flags wrong");
	a_sum_temp_cml: assert property (core_ce |=> fault_summary_byte[SUM_TEMP:SUM_OTHER] == $past(misc_now))
		else $error("temperature or logic flags wrong");
	a_word_low_match: assert property (s_access(CMD_SUM_WORD, 1'b0) |=> core_reg.rdata[7:0] == $past(core_reg.sum))
		else $error("summary word low byte mismatch");
	a_sum_write_refused: assert property (s_access(CMD_SUM_BYTE, 1'b1) |=> core_reg.rerr)
		else $error("summary byte write accepted");

	// ***********************
	// staging and readback checks
	// ***********************
	a_oc_write_staged: assert property (s_access(CMD_IN_OC_LIMIT, 1'b1) |=>
		core_reg.oc_stage == $past(link_reg.wdata) && $stable(core_reg.oc_act))
		else $error("overcurrent limit write not staged");
	a_on_ramp_staged: assert property (s_access(CMD_ON_RAMP, 1'b1) |=>
		core_reg.on_ramp_stage[$past(link_reg.page)] == $past(link_reg.wdata) && $stable(core_reg.on_ramp_act))
		else $error("turn on ramp write not staged");
	a_off_ramp_staged: assert property (s_access(CMD_OFF_RAMP, 1'b1) |=>
		core_reg.off_ramp_stage[$past(link_reg.page)] == $past(link_reg.wdata) && $stable(core_reg.off_ramp_act))
		else $error("turn off ramp write not staged");
	a_off_delay_paged: assert property (s_access(CMD_OFF_DELAY, 1'b1) |=>
		core_reg.off_dly[$past(link_reg.page)] == $past(link_reg.wdata))
		else $error("turn off delay page write wrong");
	a_on_delay_read: assert property (s_access(CMD_ON_DELAY, 1'b0) |=> core_reg.rdata == $past(sel_on_dly))
		else $error("turn on delay readback wrong");
	a_on_ramp_read: assert property (s_access(CMD_ON_RAMP, 1'b0) |=> core_reg.rdata == $past(sel_on_ramp))
		else $error("turn on ramp readback wrong");
	a_off_delay_read: assert property (s_access(CMD_OFF_DELAY, 1'b0) |=> core_reg.rdata == $past(sel_off_dly))
		else $error("turn off delay readback wrong");
	a_off_ramp_read: assert property (s_access(CMD_OFF_RAMP, 1'b0) |=> core_reg.rdata == $past(sel_off_ramp))
		else $error("turn off ramp readback wrong");
	a_commit_off_ramp: assert property (s_access(CMD_COMMIT, 1'b1) |=>
		core_reg.off_ramp_act == $past(core_reg.off_ramp_stage))
		else $error("commit did not copy staged fall time");
	a_commit_read_refused: assert property (s_access(CMD_COMMIT, 1'b0) |=> core_reg.rerr && !commit_pulse)
		else $error("commit read not refused");
	a_commit_pulse_once: assert property (core_ce && commit_pulse |=> !commit_pulse)
		else $error("commit pulse too long");
	a_ramp_hold_uncommitted: assert property (!(core_ce && core_next.commit) |=>
		$stable(core_reg.on_ramp_act) && $stable(core_reg.off_ramp_act))
		else $error("ramp time changed without commit");
	a_sum_byte_read: assert property (s_access(CMD_SUM_BYTE, 1'b0) |=>
		core_reg.rdata == {8'h00, $past(core_reg.sum)} && !core_reg.rerr)
		else $error("summary byte readback wrong");
	a_sum_word_refused: assert property (s_access(CMD_SUM_WORD, 1'b1) |=> core_reg.rerr)
		else $error("summary word write accepted");

endmodule

// ---- rtl/psl_pkg.sv ----
// constants shared by the power sequencing limit and status registers
package psl_pkg;

	// ***********************
	// command codes
	// ***********************
	localparam logic [7:0] CMD_IN_OC_LIMIT = 8'h5b;
	localparam logic [7:0] CMD_ON_DELAY    = 8'h60;
	localparam logic [7:0] CMD_ON_RAMP     = 8'h61;
	localparam logic [7:0] CMD_OFF_DELAY   = 8'h64;
	localparam logic [7:0] CMD_OFF_RAMP    = 8'h65;
	localparam logic [7:0] CMD_SUM_BYTE    = 8'h78;
	localparam logic [7:0] CMD_SUM_WORD    = 8'h79;
	localparam logic [7:0] CMD_COMMIT      = 8'he7;

	// ***********************
	// reset values
	// ***********************
	localparam logic [15:0] RST_IN_OC_LIMIT = 16'h0032;
	localparam logic [15:0] RST_ON_DELAY    = 16'h0014;
	localparam logic [15:0] RST_ON_RAMP     = 16'h01f4;
	localparam logic [15:0] RST_OFF_DELAY   = 16'h0000;
	localparam logic [15:0] RST_OFF_RAMP    = 16'h01f4;
	localparam logic [7:0]  RST_SUM_BYTE    = 8'h40;

	// ***********************
	// summary bit positions
	// ***********************
	localparam int SUM_UNUSED = 7;
	localparam int SUM_OFF    = 6;
	localparam int SUM_OV     = 5;
	localparam int SUM_OC     = 4;
	localparam int SUM_UV     = 3;
	localparam int SUM_TEMP   = 2;
	localparam int SUM_CML    = 1;
	localparam int SUM_OTHER  = 0;
	localparam int WORD_VOUT  = 15;
	localparam int WORD_IOUT  = 14;
	localparam int WORD_INPUT = 13;

	// ***********************
	// timing and output count
	// ***********************
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int DELAY_STEP_US  = 10;
	localparam int DELAY_STEP_CYC = (DELAY_STEP_US * 1000000) / CLK_PERIOD_PS;
	localparam int NUM_OUT        = 2;

endpackage

// ---- bench/psl_host.sv ----
// host model that issues commands on the link command port
`timescale 1ns/100ps
module psl_host (
	// answer side
	input  wire  logic        link_clk,
	input  wire  logic        link_busy,
	input  wire  logic        link_rsp_valid,
	input  wire  logic [15:0] link_rsp_data,
	input  wire  logic        link_rsp_err,
	// request side
	output logic              link_cmd_valid,
	output logic              link_cmd_write,
	output logic [7:0]        link_cmd_code,
	output logic              link_cmd_page,
	output logic [15:0]       link_cmd_wdata
);
	initial begin
		link_cmd_valid = 1'b0;
		link_cmd_write = 1'b0;
		link_cmd_code  = 8'h00;
		link_cmd_page  = 1'b0;
		link_cmd_wdata = 16'h0000;
	end

	// request held until taken or for at most 50 link clocks, lines inverted once released
	task automatic cmd(input logic wr, input logic [7:0] code, input logic pg, input logic [15:0] wd,
		output logic [15:0] rd, output logic err, output bit ok);
		int n;
		bit taken;
		taken = 1'b0;
		ok = 1'b0;
		@(negedge link_clk);
		link_cmd_valid = 1'b1;
		link_cmd_write = wr;
		link_cmd_code  = code;
		link_cmd_page  = pg;
		link_cmd_wdata = wd;
		for (n = 0; n < 50 && !taken; n++) begin
			@(posedge link_clk);
			taken = (link_busy === 1'b0);
		end
		@(negedge link_clk);
		link_cmd_valid = 1'b0;
		link_cmd_write = ~wr;
		link_cmd_code  = ~code;
		link_cmd_page  = ~pg;
		link_cmd_wdata = ~wd;
		for (n = 0; n < 200 && taken && !ok; n++) begin
			@(posedge link_clk);
			if (link_rsp_valid === 1'b1) begin
				ok = 1'b1;
				rd = link_rsp_data;
				err = link_rsp_err;
			end
		end
	endtask
endmodule

// ---- bench/psl_regs_bench.sv ----
// self-checking bench for the limit and status register bank
`timescale 1ns/100ps
module psl_regs_bench;
	import psl_pkg::*;
	logic              core_clk, link_clk, rst_b, core_ce;
	logic              link_cmd_valid, link_cmd_write, link_cmd_page, link_busy, link_rsp_valid, link_rsp_err;
	logic [7:0]        link_cmd_code, fault_summary_byte;
	logic [15:0]       link_cmd_wdata, link_rsp_data, act_input_overcurrent_limit;
	logic [1:0]        out_enabled, out_power_good, output_overvoltage_flag, output_overcurrent_flag, temp_flag;
	logic              input_undervoltage_flag, comm_memory_logic_flag, other_change_flag, commit_pulse;
	logic [1:0][15:0]  act_turn_on_delay, act_turn_on_ramp_time, act_turn_off_delay, act_turn_off_ramp_time;
	logic [7:0]        rw_code [5] = '{CMD_IN_OC_LIMIT, CMD_ON_DELAY, CMD_ON_RAMP, CMD_OFF_DELAY, CMD_OFF_RAMP};
	logic [15:0]       rw_rst [5] = '{RST_IN_OC_LIMIT, RST_ON_DELAY, RST_ON_RAMP, RST_OFF_DELAY, RST_OFF_RAMP};
	logic [15:0]       stg [2][5];
	logic [15:0]       act [2][5];
	logic [15:0]       rd, wd;
	logic [12:0]       pat;
	logic              err;
	int                failures, n_compared, n_commit;

	psl_regs psl_regs_i (.core_clk(core_clk), .rst_b(rst_b), .core_ce(core_ce), .link_clk(link_clk),
		.link_cmd_valid(link_cmd_valid), .link_cmd_write(link_cmd_write), .link_cmd_code(link_cmd_code),
		.link_cmd_page(link_cmd_page), .link_cmd_wdata(link_cmd_wdata), .link_busy(link_busy),
		.link_rsp_valid(link_rsp_valid), .link_rsp_data(link_rsp_data), .link_rsp_err(link_rsp_err),
		.out_enabled(out_enabled), .out_power_good(out_power_good), .output_overvoltage_flag(output_overvoltage_flag),
		.output_overcurrent_flag(output_overcurrent_flag), .temp_flag(temp_flag),
		.input_undervoltage_flag(input_undervoltage_flag), .comm_memory_logic_flag(comm_memory_logic_flag),
		.other_change_flag(other_change_flag), .act_input_overcurrent_limit(act_input_overcurrent_limit),
		.act_turn_on_delay(act_turn_on_delay), .act_turn_on_ramp_time(act_turn_on_ramp_time),
		.act_turn_off_delay(act_turn_off_delay), .act_turn_off_ramp_time(act_turn_off_ramp_time),
		.commit_pulse(commit_pulse), .fault_summary_byte(fault_summary_byte));
	psl_host psl_host_i (.link_clk(link_clk), .link_busy(link_busy), .link_rsp_valid(link_rsp_valid),
		.link_rsp_data(link_rsp_data), .link_rsp_err(link_rsp_err), .link_cmd_valid(link_cmd_valid),
		.link_cmd_write(link_cmd_write), .link_cmd_code(link_cmd_code), .link_cmd_page(link_cmd_page),
		.link_cmd_wdata(link_cmd_wdata));

	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		link_clk = 1'b0;
		#1.3;
		forever #6 link_clk = ~link_clk;
	end
	always @(posedge core_clk) if (commit_pulse === 1'b1) n_commit++;

	// ***********************
	// checking helpers
	// ***********************
	task automatic give_verdict();
		if (failures == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	function automatic logic [7:0] exp_sum();
		return {1'b0, |(~(out_enabled & out_power_good)), |output_overvoltage_flag, |output_overcurrent_flag,
			input_undervoltage_flag, |temp_flag, comm_memory_logic_flag, other_change_flag};
	endfunction
	task automatic run(input logic wr, input logic [7:0] code, input logic pg, input logic [15:0] w);
		bit ok;
		psl_host_i.cmd(wr, code, pg, w, rd, err, ok);
		if (!ok) begin
			failures++;
			$display("CHECK FAILED %0t command not answered", $time);
			give_verdict();
		end
	endtask
	task automatic read_chk(input logic [7:0] code, input logic pg, input logic [15:0] exp);
		run(1'b0, code, pg, 16'h0000);
		check_val(rd, exp, "read data");
		check_val({15'h0, err}, 16'h0000, "read status");
	endtask
	task automatic refuse_chk(input logic wr, input logic [7:0] code);
		run(wr, code, 1'b0, 16'h00ff);
		check_val({15'h0, err}, 16'h0001, "refusal status");
	endtask
	task automatic act_chk();
		repeat (3) @(posedge core_clk);
		for (int p = 0; p < 2; p++) begin
			check_val(act_input_overcurrent_limit, act[p][0], "oc in force");
			check_val(act_turn_on_delay[p], act[p][1], "on delay in force");
			check_val(act_turn_on_ramp_time[p], act[p][2], "on ramp in force");
			check_val(act_turn_off_delay[p], act[p][3], "off delay in force");
			check_val(act_turn_off_ramp_time[p], act[p][4], "off ramp in force");
		end
	endtask

	// ***********************
	// main sequence
	// ***********************
	initial begin
		void'($urandom(37));
		{rst_b, core_ce, out_enabled, out_power_good, output_overvoltage_flag, output_overcurrent_flag} = 10'h100;
		{temp_flag, input_undervoltage_flag, comm_memory_logic_flag, other_change_flag} = 5'h00;
		for (int p = 0; p < 2; p++) for (int i = 0; i < 5; i++) {stg[p][i], act[p][i]} = {rw_rst[i], rw_rst[i]};
		repeat (10) @(posedge core_clk);
		@(negedge core_clk) rst_b = 1'b1;
		repeat (4) @(posedge link_clk);
		act_chk();
		check_val({8'h0, fault_summary_byte}, 16'h0040, "summary after reset");
		for (int p = 0; p < 2; p++) for (int i = 0; i < 5; i++) read_chk(rw_code[i], 1'(p), rw_rst[i]);
		for (int p = 0; p < 2; p++) for (int i = 0; i < 5; i++) begin
			wd = 16'($urandom_range(20, 50));
			run(1'b1, rw_code[i], 1'(p), wd);
			check_val({15'h0, err}, 16'h0000, "write status");
			if (i == 0) {stg[0][0], stg[1][0]} = {wd, wd};
			else stg[p][i] = wd;
			if (i == 1 || i == 3) act[p][i] = wd;
		end
		act_chk();
		for (int p = 0; p < 2; p++) for (int i = 0; i < 5; i++) read_chk(rw_code[i], 1'(p), stg[p][i]);
		run(1'b1, CMD_COMMIT, 1'b0, 16'h0000);
		for (int p = 0; p < 2; p++) for (int i = 0; i < 5; i += 2) act[p][i] = stg[p][i];
		act_chk();
		check_val(16'(n_commit), 16'h0001, "commit pulses");
		for (int k = 0; k < 12; k++) begin
			pat = (k == 0) ? 13'h1fff : ((k == 1) ? 13'h0000 : 13'($urandom));
			@(negedge core_clk);
			{out_enabled, out_power_good, output_overvoltage_flag, output_overcurrent_flag, temp_flag} = pat[12:3];
			{input_undervoltage_flag, comm_memory_logic_flag, other_change_flag} = pat[2:0];
			repeat (2) @(posedge core_clk);
			#1 check_val({8'h0, fault_summary_byte}, {8'h0, exp_sum()}, "summary byte");
			read_chk(CMD_SUM_BYTE, k[0], {8'h0, exp_sum()});
			read_chk(CMD_SUM_WORD, k[0], {|output_overvoltage_flag, |output_overcurrent_flag,
				input_undervoltage_flag, 5'h00, exp_sum()});
		end
		refuse_chk(1'b1, CMD_SUM_BYTE);
		refuse_chk(1'b1, CMD_SUM_WORD);
		refuse_chk(1'b0, 8'h00);
		refuse_chk(1'b0, CMD_COMMIT);
		check_val({8'h0, fault_summary_byte}, {8'h0, exp_sum()}, "summary after refused write");
		check_val(16'(n_commit), 16'h0001, "commit pulses after refusals");
		wd = {8'h0, exp_sum()};
		@(negedge core_clk);
		core_ce = 1'b0;
		{output_overvoltage_flag, other_change_flag} = ~{output_overvoltage_flag, other_change_flag};
		repeat (3) @(posedge core_clk);
		#1 check_val({8'h0, fault_summary_byte}, wd, "summary frozen while disabled");
		@(negedge core_clk);
		core_ce = 1'b1;
		repeat (2) @(posedge core_clk);
		#1 check_val({8'h0, fault_summary_byte}, {8'h0, exp_sum()}, "summary after enable");
		give_verdict();
	end
	initial begin
		#200000;
		failures++;
		$display("CHECK FAILED %0t run did not finish", $time);
		give_verdict();
	end
endmodule
